// ### src/fbn_pkg.sv
// Package with register map, field layout, reset values and timing constants for the node block.
package fbn_pkg;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [7:0] FBN_OFF_NODE_STATE = 8'h00;
  localparam logic [7:0] FBN_OFF_OBJ_PARAM  = 8'h04;
  localparam logic [7:0] FBN_OFF_TERM_RATE  = 8'h08;
  localparam logic [7:0] FBN_OFF_COMMAND    = 8'h0c;
  localparam logic [7:0] FBN_OFF_ACTIVE     = 8'h10;
  localparam logic [7:0] FBN_OFF_SWITCHES   = 8'h14;
  localparam logic [7:0] FBN_OFF_INT_STATUS = 8'h18;
  localparam logic [7:0] FBN_OFF_INT_MASK   = 8'h1c;
  localparam logic [7:0] FBN_OFF_SAVED      = 8'h20;

  // ==========================================================================
  // Node state bits, written by the node firmware.
  localparam int FBN_ST_ONLINE     = 0;
  localparam int FBN_ST_DUP_DONE   = 1;
  localparam int FBN_ST_CONN_EST   = 2;
  localparam int FBN_ST_MASTER     = 3;
  localparam int FBN_ST_CONFIG_OK  = 4;
  localparam int FBN_ST_RECOV_ERR  = 5;
  localparam int FBN_ST_IO_WAIT    = 6;
  localparam int FBN_ST_FATAL      = 7;
  localparam int FBN_ST_COMM_FAIL  = 8;
  localparam int FBN_ST_WIDTH      = 9;

  // Command bits.
  localparam int FBN_CMD_SAVE    = 0;
  localparam int FBN_CMD_RESTART = 1;

  // Interrupt event bits.
  localparam int FBN_IRQ_LED     = 0;
  localparam int FBN_IRQ_APPLIED = 1;
  localparam int FBN_IRQ_FAULT   = 2;
  localparam int FBN_IRQ_WIDTH   = 3;

  // ==========================================================================
  // Field positions and widths.
  localparam int FBN_ADDR_W      = 6;
  localparam int FBN_RATE_W      = 2;
  localparam int FBN_RATE_LSB    = 8;
  localparam int FBN_SW_W        = 4;
  localparam int FBN_LED_LSB     = 16;
  localparam logic [7:0] FBN_ADDR_MAX   = 8'h3f;
  localparam logic [3:0] FBN_RATE_MAX   = 4'h2;
  localparam logic [7:0] FBN_TENS_WEIGHT = 8'h0a;

  // Bit-rate codes and terminal values in kbit/s.
  localparam logic [1:0] FBN_RATE_125 = 2'h0;
  localparam logic [1:0] FBN_RATE_250 = 2'h1;
  localparam logic [1:0] FBN_RATE_500 = 2'h2;
  localparam logic [9:0] FBN_KBIT_125 = 10'h07d;
  localparam logic [9:0] FBN_KBIT_250 = 10'h0fa;
  localparam logic [9:0] FBN_KBIT_500 = 10'h1f4;

  // Values after reset of the stored parameters.
  localparam logic [5:0] FBN_RST_ADDR = 6'h3f;
  localparam logic [1:0] FBN_RST_RATE = 2'h0;

  // ==========================================================================
  // Blink timing.
  localparam int  FBN_CLK_MHZ       = 250;
  localparam int  FBN_BLINK_HALF_MS = 500;
  localparam int  FBN_BLINK_HALF_CYC = FBN_BLINK_HALF_MS * FBN_CLK_MHZ * 1000;

  // LED states, one-hot.
  typedef enum logic [4:0] {
    FBN_LED_OFF       = 5'h01,
    FBN_LED_BLINK_GRN = 5'h02,
    FBN_LED_GREEN     = 5'h04,
    FBN_LED_BLINK_RED = 5'h08,
    FBN_LED_RED       = 5'h10
  } fbn_led_t;

endpackage

// ### src/fbn_blink.sv
// Free-running blink phase generator for the status LED.
`timescale 1ns/1ps
`default_nettype none
module fbn_blink #(
  parameter int HALF_CYCLES = fbn_pkg::FBN_BLINK_HALF_CYC
) (
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Phase.
  output logic      phase
);
  import fbn_pkg::*;

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        phase_q;
  logic        phase_d;

  // ==========================================================================
  // Counter.
  always_comb begin
    cnt_d   = cnt_q + 32'h1;
    phase_d = phase_q;
    if (cnt_q >= 32'(HALF_CYCLES - 1)) begin
      cnt_d   = 32'h0;
      phase_d = ~phase_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= 32'h0;
      phase_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      phase_q <= phase_d;
    end
  end

  assign phase = phase_q;

endmodule
`default_nettype wire

// ### src/fbn_cfg_select.sv
// Chooses node address and bit-rate code from rotary switches or stored values.
`timescale 1ns/1ps
`default_nettype none
module fbn_cfg_select (
  // Switches.
  input  wire logic [fbn_pkg::FBN_SW_W-1:0]   tens_digit_switch,
  input  wire logic [fbn_pkg::FBN_SW_W-1:0]   units_digit_switch,
  input  wire logic [fbn_pkg::FBN_SW_W-1:0]   rate_switch,
  // Stored values.
  input  wire logic [fbn_pkg::FBN_ADDR_W-1:0] saved_addr,
  input  wire logic [fbn_pkg::FBN_RATE_W-1:0] saved_rate,
  // Selection.
  output logic      [fbn_pkg::FBN_ADDR_W-1:0] sel_addr,
  output logic      [fbn_pkg::FBN_RATE_W-1:0] sel_rate
);
  import fbn_pkg::*;

  logic [7:0] combined;

  // ==========================================================================
  // Selection.
  always_comb begin
    combined = 8'(tens_digit_switch * FBN_TENS_WEIGHT) + 8'(units_digit_switch);
    if (tens_digit_switch <= 4'h9 && units_digit_switch <= 4'h9 && combined <= FBN_ADDR_MAX) begin
      sel_addr = combined[FBN_ADDR_W-1:0];
    end else begin
      sel_addr = saved_addr;
    end
    if (rate_switch <= FBN_RATE_MAX) begin
      sel_rate = rate_switch[FBN_RATE_W-1:0];
    end else begin
      sel_rate = saved_rate;
    end
  end

endmodule
`default_nettype wire

// ### src/fbn_node.sv
// Fieldbus node status LED, address and bit-rate selection with an APB register file.
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - LED dark while not online, including before duplicate address check finishes; the code still shows steady or blinking red first on any fault or error bit.
// - Steady green when online, connections established, master allocated and configuration good.
// - Blink green when online but unconnected, unallocated or badly configured.
// - Blink red on recoverable error or an I/O connection waiting.
// - Steady red on unrecoverable fault or communication failure, e.g. bus-off.
// - Node address from tens and units switches when 0 to 63.
// - Switches above 63 select stored address, written via object class 0x03 attr 1.
// - Rate switch 0, 1, 2 give 125, 250, 500 kbit/s.
// - Rate switch above 2 selects stored rate from terminal or object attr 2.
// - Written values act only after save to storage and restart.
// - Only 125, 250 and 500 kbit rates are supported.
module fbn_node #(
  parameter int BLINK_HALF_CYCLES = fbn_pkg::FBN_BLINK_HALF_CYC
) (
  // APB slave.
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [7:0]                      paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // Front switches.
  input  wire logic [fbn_pkg::FBN_SW_W-1:0]    tens_digit_switch,
  input  wire logic [fbn_pkg::FBN_SW_W-1:0]    units_digit_switch,
  input  wire logic [fbn_pkg::FBN_SW_W-1:0]    rate_switch,
  // Link conditions.
  input  wire logic                            bus_off,
  input  wire logic                            dup_addr_seen,
  // Node configuration and LED.
  output logic      [fbn_pkg::FBN_ADDR_W-1:0]  node_addr,
  output logic      [fbn_pkg::FBN_RATE_W-1:0]  bit_rate,
  output logic                                 led_green,
  output logic                                 led_red,
  // Interrupt.
  output logic                                 irq
);
  import fbn_pkg::*;

  logic [FBN_ST_WIDTH-1:0]  state_q;
  logic [FBN_ST_WIDTH-1:0]  state_d;
  logic [FBN_ADDR_W-1:0]    pend_addr_q;
  logic [FBN_ADDR_W-1:0]    pend_addr_d;
  logic [FBN_RATE_W-1:0]    pend_rate_q;
  logic [FBN_RATE_W-1:0]    pend_rate_d;
  logic [FBN_ADDR_W-1:0]    saved_addr_q;
  logic [FBN_ADDR_W-1:0]    saved_addr_d;
  logic [FBN_RATE_W-1:0]    saved_rate_q;
  logic [FBN_RATE_W-1:0]    saved_rate_d;
  logic [FBN_ADDR_W-1:0]    act_addr_q;
  logic [FBN_ADDR_W-1:0]    act_addr_d;
  logic [FBN_RATE_W-1:0]    act_rate_q;
  logic [FBN_RATE_W-1:0]    act_rate_d;
  logic                     restart_q;
  logic                     restart_d;
  logic [FBN_IRQ_WIDTH-1:0] ists_q;
  logic [FBN_IRQ_WIDTH-1:0] ists_d;
  logic [FBN_IRQ_WIDTH-1:0] imask_q;
  logic [FBN_IRQ_WIDTH-1:0] imask_d;
  logic [31:0]              rdata_q;
  logic [31:0]              rdata_d;
  fbn_led_t                 led_q;
  fbn_led_t                 led_d;
  logic                     grn_q;
  logic                     grn_d;
  logic                     red_q;
  logic                     red_d;
  logic                     fault_q;
  logic                     fault_d;
  logic                     phase;
  logic [FBN_ADDR_W-1:0]    sel_addr;
  logic [FBN_RATE_W-1:0]    sel_rate;
  logic                     setup;
  logic                     wr;
  logic                     mapped;
  logic                     fatal;
  logic                     online;
  logic [FBN_IRQ_WIDTH-1:0] events;

  // ==========================================================================
  // Submodules.
  fbn_blink #(
    .HALF_CYCLES(BLINK_HALF_CYCLES)
  ) u_blink (
    .pclk   (pclk),
    .presetn(presetn),
    .phase  (phase)
  );

  fbn_cfg_select u_sel (
    .tens_digit_switch (tens_digit_switch),
    .units_digit_switch(units_digit_switch),
    .rate_switch       (rate_switch),
    .saved_addr        (saved_addr_q),
    .saved_rate        (saved_rate_q),
    .sel_addr          (sel_addr),
    .sel_rate          (sel_rate)
  );

  // ==========================================================================
  // Bus decode.
  always_comb begin
    unique case (paddr)
      FBN_OFF_NODE_STATE, FBN_OFF_OBJ_PARAM, FBN_OFF_TERM_RATE, FBN_OFF_COMMAND,
      FBN_OFF_ACTIVE, FBN_OFF_SWITCHES, FBN_OFF_INT_STATUS, FBN_OFF_INT_MASK,
      FBN_OFF_SAVED: mapped = 1'b1;
      default:       mapped = 1'b0;
    endcase
    setup = psel & ~penable;
    wr    = psel & penable & pwrite & mapped;
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = rdata_q;

  // ==========================================================================
  // Registers and configuration.
  always_comb begin
    state_d      = state_q;
    pend_addr_d  = pend_addr_q;
    pend_rate_d  = pend_rate_q;
    saved_addr_d = saved_addr_q;
    saved_rate_d = saved_rate_q;
    act_addr_d   = act_addr_q;
    act_rate_d   = act_rate_q;
    restart_d    = 1'b0;
    imask_d      = imask_q;
    if (wr) begin
      unique case (paddr)
        FBN_OFF_NODE_STATE: state_d = pwdata[FBN_ST_WIDTH-1:0];
        FBN_OFF_OBJ_PARAM: begin
          pend_addr_d = pwdata[FBN_ADDR_W-1:0];
          if (pwdata[FBN_RATE_LSB +: FBN_RATE_W] <= FBN_RATE_500) begin
            pend_rate_d = pwdata[FBN_RATE_LSB +: FBN_RATE_W];
          end
        end
        FBN_OFF_TERM_RATE: begin
          unique case (pwdata[9:0])
            FBN_KBIT_125: pend_rate_d = FBN_RATE_125;
            FBN_KBIT_250: pend_rate_d = FBN_RATE_250;
            FBN_KBIT_500: pend_rate_d = FBN_RATE_500;
            default:      pend_rate_d = pend_rate_q;
          endcase
        end
        FBN_OFF_COMMAND: begin
          if (pwdata[FBN_CMD_SAVE]) begin
            saved_addr_d = pend_addr_q;
            saved_rate_d = pend_rate_q;
          end
          restart_d = pwdata[FBN_CMD_RESTART];
        end
        FBN_OFF_INT_MASK: imask_d = pwdata[FBN_IRQ_WIDTH-1:0];
        default: ;
      endcase
    end
    if (restart_q) begin
      act_addr_d = sel_addr;
      act_rate_d = sel_rate;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q      <= '0;
      pend_addr_q  <= FBN_RST_ADDR;
      pend_rate_q  <= FBN_RST_RATE;
      saved_addr_q <= FBN_RST_ADDR;
      saved_rate_q <= FBN_RST_RATE;
      act_addr_q   <= FBN_RST_ADDR;
      act_rate_q   <= FBN_RST_RATE;
      restart_q    <= 1'b1;
      imask_q      <= '0;
    end else begin
      state_q      <= state_d;
      pend_addr_q  <= pend_addr_d;
      pend_rate_q  <= pend_rate_d;
      saved_addr_q <= saved_addr_d;
      saved_rate_q <= saved_rate_d;
      act_addr_q   <= act_addr_d;
      act_rate_q   <= act_rate_d;
      restart_q    <= restart_d;
      imask_q      <= imask_d;
    end
  end

  // ==========================================================================
  // Read data, loaded in the setup cycle.
  always_comb begin
    rdata_d = rdata_q;
    if (setup) begin
      unique case (paddr)
        FBN_OFF_NODE_STATE: rdata_d = 32'(state_q);
        FBN_OFF_OBJ_PARAM:  rdata_d = 32'({pend_rate_q, 2'h0, pend_addr_q});
        FBN_OFF_ACTIVE:     rdata_d = {11'h0, led_q, 6'h0, act_rate_q, 2'h0, act_addr_q};
        FBN_OFF_SWITCHES:   rdata_d = 32'({rate_switch, tens_digit_switch, units_digit_switch});
        FBN_OFF_INT_STATUS: rdata_d = 32'(ists_q);
        FBN_OFF_INT_MASK:   rdata_d = 32'(imask_q);
        FBN_OFF_SAVED:      rdata_d = 32'({saved_rate_q, 2'h0, saved_addr_q});
        default:            rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================================
  // LED state.
  always_comb begin
    online  = state_q[FBN_ST_ONLINE] & state_q[FBN_ST_DUP_DONE];
    fatal   = state_q[FBN_ST_FATAL] | state_q[FBN_ST_COMM_FAIL] | bus_off | dup_addr_seen;
    fault_d = fatal;
    if (fatal) begin
      led_d = FBN_LED_RED;
    end else if (state_q[FBN_ST_RECOV_ERR] | state_q[FBN_ST_IO_WAIT]) begin
      led_d = FBN_LED_BLINK_RED;
    end else if (!online) begin
      led_d = FBN_LED_OFF;
    end else if (state_q[FBN_ST_CONN_EST] & state_q[FBN_ST_MASTER] & state_q[FBN_ST_CONFIG_OK]) begin
      led_d = FBN_LED_GREEN;
    end else begin
      led_d = FBN_LED_BLINK_GRN;
    end
    unique case (led_q)
      FBN_LED_OFF: begin
        grn_d = 1'b0;
        red_d = 1'b0;
      end
      FBN_LED_BLINK_GRN: begin
        grn_d = phase;
        red_d = 1'b0;
      end
      FBN_LED_GREEN: begin
        grn_d = 1'b1;
        red_d = 1'b0;
      end
      FBN_LED_BLINK_RED: begin
        grn_d = 1'b0;
        red_d = phase;
      end
      FBN_LED_RED: begin
        grn_d = 1'b0;
        red_d = 1'b1;
      end
      default: begin
        grn_d = 1'b0;
        red_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_q   <= FBN_LED_OFF;
      grn_q   <= 1'b0;
      red_q   <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      led_q   <= led_d;
      grn_q   <= grn_d;
      red_q   <= red_d;
      fault_q <= fault_d;
    end
  end

  // ==========================================================================
  // Interrupts, set wins over clear.
  always_comb begin
    events                  = '0;
    events[FBN_IRQ_LED]     = (led_d != led_q);
    events[FBN_IRQ_APPLIED] = restart_q;
    events[FBN_IRQ_FAULT]   = fatal & ~fault_q;
    ists_d = ists_q;
    if (wr && paddr == FBN_OFF_INT_STATUS) begin
      ists_d = ists_q & ~pwdata[FBN_IRQ_WIDTH-1:0];
    end
    ists_d = ists_d | events;
  end

  assign irq = |(ists_q & imask_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ists_q <= '0;
    end else begin
      ists_q <= ists_d;
    end
  end

  // ==========================================================================
  // Outputs.
  assign node_addr = act_addr_q;
  assign bit_rate  = act_rate_q;
  assign led_green = grn_q;
  assign led_red   = red_q;

endmodule
`default_nettype wire

// ### bench/fbn_node_props.sv
// Checker of the node block port behaviour.
`timescale 1ns/1ps
`default_nettype none
module fbn_node_props #(
  parameter int BLINK_HALF_CYCLES = 4
) (
  // APB.
  input wire logic                           pclk,
  input wire logic                           presetn,
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic                           pwrite,
  input wire logic [7:0]                     paddr,
  input wire logic [31:0]                    pwdata,
  input wire logic                           pready,
  input wire logic                           pslverr,
  // Link and node outputs.
  input wire logic                           bus_off,
  input wire logic                           dup_addr_seen,
  input wire logic [fbn_pkg::FBN_ADDR_W-1:0] node_addr,
  input wire logic [fbn_pkg::FBN_RATE_W-1:0] bit_rate,
  input wire logic                           led_green,
  input wire logic                           led_red
);
  import fbn_pkg::*;
  // ====
  // Mirror of the node state register and the LED causes.
  logic [8:0] st_q;
  logic [8:0] st_d;
  logic       rst_wr;
  logic       red_c;
  logic       brd_c;
  logic       on_c;
  logic       grn_c;
  assign rst_wr = psel && penable && pwrite && paddr == FBN_OFF_COMMAND && pwdata[1];
  assign red_c = st_q[7] || st_q[8] || bus_off || dup_addr_seen;
  assign brd_c = !red_c && (st_q[5] || st_q[6]);
  assign on_c = !red_c && !brd_c && st_q[0] && st_q[1];
  assign grn_c = on_c && st_q[2] && st_q[3] && st_q[4];
  always_comb begin
    st_d = st_q;
    if (psel && penable && pwrite && paddr == FBN_OFF_NODE_STATE) st_d = pwdata[8:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_q <= 9'h000;
    else st_q <= st_d;
  end
  // ====
  // Assertions.
  ready_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel |-> pready) else $error("Ready low during a transfer");
  slverr_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr == (psel && penable && (paddr > FBN_OFF_SAVED || paddr[1:0] != 2'h0)))
    else $error("Error response does not match the address map");
  led_dark_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!red_c && !brd_c && !on_c) [*3] |-> !led_green && !led_red)
    else $error("LED lit while offline");
  led_green_a: assert property (@(posedge pclk) disable iff (!presetn)
    grn_c [*3] |-> led_green && !led_red) else $error("Steady green missing");
  blink_green_a: assert property (@(posedge pclk) disable iff (!presetn)
    (on_c && !grn_c) [*8] |-> !led_red && led_green != $past(led_green, BLINK_HALF_CYCLES))
    else $error("Green does not blink");
  blink_red_a: assert property (@(posedge pclk) disable iff (!presetn)
    brd_c [*8] |-> !led_green && led_red != $past(led_red, BLINK_HALF_CYCLES))
    else $error("Red does not blink");
  red_steady_a: assert property (@(posedge pclk) disable iff (!presetn)
    red_c [*3] |-> led_red && !led_green) else $error("Steady red missing");
  cfg_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed({node_addr, bit_rate}) |-> $past(rst_wr, 2) || !$past(presetn, 2))
    else $error("Configuration changed without a restart");
endmodule
bind fbn_node fbn_node_props #(.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)) u_fbn_node_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .bus_off, .dup_addr_seen, .node_addr, .bit_rate, .led_green, .led_red
);
`default_nettype wire

// ### bench/fbn_link_model.sv
// Behavioural model of the network side that reports link faults to the node.
`timescale 1ns/1ps
`default_nettype none
module fbn_link_model (
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Scenario controls.
  input  wire logic go_bus_off,
  input  wire logic go_dup,
  // Link conditions.
  output logic      bus_off,
  output logic      dup_addr_seen
);
  // ====
  // Conditions change just after a clock edge, as a bus controller reports them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_off <= 1'b0;
      dup_addr_seen <= 1'b0;
    end else begin
      bus_off <= go_bus_off;
      dup_addr_seen <= go_dup;
    end
  end
endmodule
`default_nettype wire

// ### bench/fbn_node_tb.sv
// Self-checking testbench of the node block.
`timescale 1ns/1ps
`default_nettype none
module fbn_node_tb;
  import fbn_pkg::*;
  // ====
  // Signals and instances.
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        bus_off, dup_addr_seen, led_green, led_red, irq, go_off, go_dup;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  tens, units, rsw;
  logic [5:0]  node_addr;
  logic [1:0]  bit_rate;
  int          n_errors, cmp_count;
  localparam logic [10:0] led_st [12] = '{11'h000, 11'h001, 11'h01f, 11'h003, 11'h00b,
    11'h00f, 11'h020, 11'h05f, 11'h0bf, 11'h11f, 11'h21f, 11'h41f};
  localparam logic [7:0] led_ex [12] = '{8'h00, 8'h00, 8'h80, 8'h40, 8'h40, 8'h40,
    8'h04, 8'h04, 8'h08, 8'h08, 8'h08, 8'h08};
  localparam logic [9:0] kbit [3] = '{FBN_KBIT_125, FBN_KBIT_250, FBN_KBIT_500};
  fbn_node #(.BLINK_HALF_CYCLES(4)) u_fbn_node (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tens_digit_switch(tens), .units_digit_switch(units), .rate_switch(rsw),
    .bus_off, .dup_addr_seen, .node_addr, .bit_rate, .led_green, .led_red, .irq);
  fbn_link_model u_fbn_link_model (.pclk, .presetn, .go_bus_off(go_off), .go_dup,
    .bus_off, .dup_addr_seen);
  // ====
  // Shared tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("mismatches %0d of %0d compares", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) begin
      n_errors++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic restart(input logic [31:0] d);
    apb(1'b1, FBN_OFF_COMMAND, d);
    repeat (3) @(posedge pclk);
  endtask
  // ====
  // Scenarios.
  task automatic led_case(input logic [10:0] c, input logic [7:0] e);
    logic [3:0] g, r;
    g = 4'h0;
    r = 4'h0;
    apb(1'b1, FBN_OFF_NODE_STATE, {23'h0, c[8:0]});
    go_off <= c[9];
    go_dup <= c[10];
    repeat (4) @(posedge pclk);
    repeat (8) begin
      @(negedge pclk);
      g += {3'h0, led_green};
      r += {3'h0, led_red};
    end
    chk({24'h0, g, r}, {24'h0, e});
  endtask
  task automatic cfg_case;
    chk(32'({node_addr, bit_rate}), 32'({6'h19, 2'h1}));
    apb(1'b0, FBN_OFF_SWITCHES, 32'h0);
    chk(rd, 32'h125);
    apb(1'b0, 8'h24, 32'h0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    tens <= 4'h7;
    rsw <= 4'h3;
    apb(1'b1, FBN_OFF_OBJ_PARAM, 32'h215);
    restart(32'h2);
    chk(32'({node_addr, bit_rate}), 32'({6'h3f, 2'h0}));
    apb(1'b1, FBN_OFF_COMMAND, 32'h1);
    restart(32'h2);
    chk(32'({node_addr, bit_rate}), 32'({6'h15, 2'h2}));
    apb(1'b1, FBN_OFF_OBJ_PARAM, 32'h30a);
    restart(32'h3);
    chk(32'({node_addr, bit_rate}), 32'({6'h0a, 2'h2}));
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, FBN_OFF_TERM_RATE, {22'h0, kbit[k]});
      restart(32'h3);
      chk(32'(bit_rate), k);
    end
    apb(1'b1, FBN_OFF_TERM_RATE, 32'h12c);
    restart(32'h3);
    chk(32'(bit_rate), 32'h2);
    for (int k = 0; k < 3; k++) begin
      rsw <= 4'(k);
      restart(32'h2);
      chk(32'(bit_rate), k);
    end
    for (int k = 0; k < 4; k++) begin
      {tens, units} <= (k == 0) ? 8'h63 : (k == 1) ? 8'h64 : (k == 2) ? 8'h00 : 8'h0a;
      restart(32'h2);
      chk(32'(node_addr), (k == 0) ? 63 : (k == 2) ? 0 : 10);
    end
  endtask
  task automatic irq_case;
    apb(1'b1, FBN_OFF_INT_MASK, 32'h0);
    apb(1'b1, FBN_OFF_INT_STATUS, 32'h7);
    restart(32'h2);
    chk(32'(irq), 32'h0);
    apb(1'b0, FBN_OFF_INT_STATUS, 32'h0);
    chk(rd & 32'h2, 32'h2);
    apb(1'b1, FBN_OFF_INT_MASK, 32'h2);
    @(negedge pclk);
    chk(32'(irq), 32'h1);
    apb(1'b1, FBN_OFF_INT_STATUS, 32'h2);
    @(negedge pclk);
    chk(32'(irq), 32'h0);
  endtask
  // ====
  // Clock, reset and main sequence.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, go_off, go_dup} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {tens, units, rsw} = 12'h251;
    n_errors = 0;
    cmp_count = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    cfg_case();
    irq_case();
    foreach (led_st[i]) led_case(led_st[i], led_ex[i]);
    finish_test();
  end
endmodule
`default_nettype wire
